//--- design/emc_consts.svh
/*
 * constants of the controller: map, widths, boot codes.
 * assumes inclusion by bare name.
 */
`ifndef EMC_CONSTS_SVH
`define EMC_CONSTS_SVH

`define EMC_BANK_LOG2      27
`define EMC_SPACE_LOG2     30
`define EMC_BANK6_BASE     32'h3000_0000
`define EMC_SIZE_MIN_LOG2  21
`define EMC_SIZE_CODE_MAX  3'h6
`define EMC_W8             2'h0
`define EMC_W16            2'h1
`define EMC_W32            2'h2
`define EMC_BOOT_NAND      2'h0
`define EMC_BOOT_ROM16     2'h1
`define EMC_BOOT_ROM32     2'h2
`define EMC_BOOT_TEST      2'h3
`define EMC_SYNC_SETTLE    2'h3

`endif

//--- design/emc_decode.sv
/*
 * address decode: bank select, address shift, sdram bank bits.
 * assumes size code 0..6 for 2 MB .. 128 MB.
 */
`timescale 1ns/1ps
`include "emc_consts.svh"
module emc_decode (
    input  wire logic [31:0] addr,
    input  wire logic [2:0]  size_code,
    input  wire logic [15:0] bank_width,
    input  wire logic [1:0]  boot_width,
    input  wire logic        sdram_four_banks,
    output logic [2:0]  bank,
    output logic        hit,
    output logic [1:0]  width,
    output logic [26:0] mem_addr,
    output logic [1:0]  sdram_bank_addr
);
    logic [29:0] upper_off;
    logic [29:0] size_bytes;
    logic [26:0] off;
    logic [4:0]  top;
    logic [2:0]  code;

    always_comb begin
        code       = (size_code > `EMC_SIZE_CODE_MAX) ? `EMC_SIZE_CODE_MAX : size_code;
        upper_off  = addr[29:0] - 30'(`EMC_BANK6_BASE);
        size_bytes = 30'h20_0000 << code;                                // [R05]
        bank       = addr[29:27];                                        // [R01]
        hit        = (addr[31:30] == 2'h0);
        off        = addr[26:0];
        if (addr[29:28] == 2'h3) begin                                   // [R04]
            if (upper_off < size_bytes) begin
                bank = 3'h6;
            end else if (upper_off < (size_bytes << 1)) begin
                bank = 3'h7;
            end else begin
                hit = 1'b0;
            end
            off = upper_off[26:0] & (size_bytes[26:0] - 27'h1);
        end
        // bank 0 only knows 16 or 32 bits
        width = (bank == 3'h0) ? boot_width : bank_width[2*bank +: 2];   // [R02]
        if (width == 2'h3) begin
            width = `EMC_W32;
        end
        unique case (width)                                              // [R10]
            `EMC_W8:  mem_addr = off;
            `EMC_W16: mem_addr = {1'b0, off[26:1]};
            default:  mem_addr = {2'h0, off[26:2]};
        endcase
        top = 5'(`EMC_SIZE_MIN_LOG2 - 1) + {2'h0, code};                 // [R11]
        sdram_bank_addr = sdram_four_banks ? {off[top], off[top - 5'h1]}
                                           : {1'b0, off[top]};
    end
endmodule : emc_decode

//--- design/emc_pkg.sv
/*
 * types of the controller.
 * assumes emc_consts.svh for numbers.
 */
package emc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_ACCESS = 4'h2,
        ST_WAIT   = 4'h4,
        ST_HOLD   = 4'h8
    } state_t;

    typedef struct packed {
        state_t      state;
        logic [1:0]  settle;
        logic        boot_done;
        logic [1:0]  boot_bank_width_status;
        logic [3:0]  count;
        logic        is_write;
        logic        wait_on;
        logic [7:0]  bank_chip_select_n;
        logic        read_strobe_n;
        logic        write_strobe_n;
        logic [26:0] mem_addr;
        logic [1:0]  sdram_bank_addr;
        logic [31:0] mem_data_out;
        logic        addr_oe;
        logic        ctrl_oe;
        logic        data_oe;
        logic        bus_hold_grant_n;
        logic        req_ready;
        logic        req_done;
        logic        req_error;
        logic [31:0] req_rdata;
        logic        sdram_cke;
        logic        sdram_self_refresh;
    } ctrl_t;

endpackage : emc_pkg

//--- design/emc_sync.sv
/*
 * two flop synchroniser for pins.
 * assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module emc_sync #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second flop
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1 <= INIT;
            synced <= INIT;
        end else begin
            stage1 <= pin;
            synced <= stage1;
        end
    end
endmodule : emc_sync

//--- design/external_memory_controller.sv
/*
 * external memory controller: decode, static access cycle with
 * wait stretching, bus hold, boot bank width, sdram
 * power states.
 * assumes one 20 MHz bus clock; pins resolved outside from the
 * output enables; configuration is plain levels.
 */
// How it works
// [R01] eight banks of 128 MB, 1 GB total
// [R02] banks 8/16/32 bit, bank zero 16/32
// [R03] six static banks, two upper may be sdram
// [R04] bank six at 0x3000_0000, seven follows it
// [R05] banks six and seven share one size
// [R06] software selects little or big endian
// [R07] sdram self-refresh and power-down supported
// [R08] bank zero width caught from boot pins
// [R09] boot pins: nand, rom16, rom32, test
// [R10] address shifted by bus width
// [R11] sdram bank bits are top range bits
// [R12] wait low stretches read strobe when enabled
// [R13] wait sampled from one clock before end
// [R14] strobe ends clock after wait seen high
// [R15] write strobe stretched same as read
// [R16] hold request answered by grant low
// [R17] grant low floats address, data, controls
// [R18] request released, grant released, bus driven
// [R19] external master drives bus only when granted
// [R20] per-bank wait enable bit
// [R21] bank zero width readable from boot pins
// [R22] all counts in bus clock cycles
`timescale 1ns/1ps
`include "emc_consts.svh"
module external_memory_controller (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic [31:0] req_addr,
    input  wire logic [31:0] req_wdata,
    output logic             req_ready,
    output logic             req_done,
    output logic             req_error,
    output logic [31:0]      req_rdata,
    input  wire logic [15:0] bank_width,
    input  wire logic [7:0]  bank_wait_enable,
    input  wire logic [31:0] bank_access_cycles,
    input  wire logic [2:0]  bank67_size,
    input  wire logic [1:0]  bank67_is_sdram,
    input  wire logic        sdram_four_banks,
    input  wire logic        big_endian,
    input  wire logic        self_refresh_req,
    input  wire logic        power_down_req,
    input  wire logic [1:0]  boot_mode_pins,
    input  wire logic        ext_wait_n,
    input  wire logic        bus_hold_request_n,
    input  wire logic [31:0] mem_data_in,
    output logic [7:0]       bank_chip_select_n,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic [26:0]      mem_addr,
    output logic [1:0]       sdram_bank_addr,
    output logic [31:0]      mem_data_out,
    output logic             addr_oe,
    output logic             ctrl_oe,
    output logic             data_oe,
    output logic             bus_hold_grant_n,
    output logic [1:0]       boot_bank_width_status,
    output logic             sdram_cke,
    output logic             sdram_self_refresh
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [1:0] boot_sync;
    logic       wait_sync_n;
    logic       hold_req_sync_n;

    emc_sync #(.WIDTH(2), .INIT(2'h0)) u_boot_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (boot_mode_pins),
        .synced  (boot_sync)
    );

    emc_sync #(.WIDTH(1), .INIT(1'b1)) u_wait_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (ext_wait_n),
        .synced  (wait_sync_n)
    );

    emc_sync #(.WIDTH(1), .INIT(1'b1)) u_hold_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (bus_hold_request_n),
        .synced  (hold_req_sync_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    emc_pkg::ctrl_t r;
    emc_pkg::ctrl_t next_r;

    logic [2:0]  dec_bank;
    logic        dec_hit;
    logic [1:0]  dec_width;
    logic [26:0] dec_mem_addr;
    logic [1:0]  dec_sdram_bank;
    logic [1:0]  boot_width;

    // nand and test boots run bank zero at 16 bit
    assign boot_width = (r.boot_bank_width_status == `EMC_BOOT_ROM32) ? `EMC_W32
                                                                     : `EMC_W16;  // [R09]

    emc_decode u_decode (
        .addr             (req_addr),
        .size_code        (bank67_size),
        .bank_width       (bank_width),
        .boot_width       (boot_width),
        .sdram_four_banks (sdram_four_banks),
        .bank             (dec_bank),
        .hit              (dec_hit),
        .width            (dec_width),
        .mem_addr         (dec_mem_addr),
        .sdram_bank_addr  (dec_sdram_bank)
    );

    function automatic logic [31:0] swap32(input logic [31:0] d, input logic en);
        swap32 = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    endfunction : swap32

    logic [3:0] tacc;
    logic       sdram_bank;
    logic       low_power;

    assign tacc       = bank_access_cycles[4*dec_bank +: 4];                         // [R22]
    assign sdram_bank = dec_bank[2] & dec_bank[1] & bank67_is_sdram[dec_bank[0]];    // [R03]
    assign low_power  = self_refresh_req | power_down_req;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r           = r;
        next_r.req_done  = 1'b0;
        next_r.req_error = 1'b0;

        // boot pins settle before capture
        if (!r.boot_done) begin
            if (r.settle == `EMC_SYNC_SETTLE) begin
                next_r.boot_bank_width_status = boot_sync;                         // [R08] [R21]
                next_r.boot_done              = 1'b1;
            end else begin
                next_r.settle = r.settle + 2'h1;
            end
        end

        unique case (r.state)
            emc_pkg::ST_IDLE: begin
                next_r.sdram_cke          = ~low_power;                            // [R07]
                next_r.sdram_self_refresh = self_refresh_req;
                next_r.req_ready          = r.boot_done & hold_req_sync_n & ~low_power;
                if (!hold_req_sync_n) begin
                    next_r.state            = emc_pkg::ST_HOLD;
                    next_r.bus_hold_grant_n = 1'b0;                                // [R16]
                    next_r.addr_oe          = 1'b0;                                // [R17]
                    next_r.ctrl_oe          = 1'b0;
                    next_r.data_oe          = 1'b0;
                    next_r.req_ready        = 1'b0;
                end else if (req_valid && r.req_ready) begin
                    next_r.req_ready = 1'b0;
                    if (!dec_hit) begin
                        next_r.req_done  = 1'b1;
                        next_r.req_error = 1'b1;
                    end else begin
                        next_r.state                        = emc_pkg::ST_ACCESS;
                        next_r.count                        = (tacc == 4'h0) ? 4'h1 : tacc;
                        next_r.is_write                     = req_write;
                        next_r.wait_on                      = bank_wait_enable[dec_bank]; // [R20]
                        next_r.mem_addr                     = dec_mem_addr;        // [R10]
                        next_r.sdram_bank_addr              = sdram_bank ? dec_sdram_bank
                                                                         : 2'h0;   // [R11]
                        next_r.bank_chip_select_n           = 8'hFF;
                        next_r.bank_chip_select_n[dec_bank] = 1'b0;                // [R01]
                        next_r.read_strobe_n                = req_write;
                        next_r.write_strobe_n               = ~req_write;
                        next_r.mem_data_out                 = swap32(req_wdata, big_endian); // [R06]
                        next_r.data_oe                      = req_write;
                    end
                end
            end
            emc_pkg::ST_ACCESS: begin
                next_r.count = r.count - 4'h1;
                // wait looked at from last counted clock
                if (r.count == 4'h1) begin                                         // [R13]
                    if (r.wait_on && !wait_sync_n) begin
                        next_r.state = emc_pkg::ST_WAIT;                           // [R12] [R15]
                    end else begin
                        next_r.state = emc_pkg::ST_IDLE;
                    end
                end
            end
            emc_pkg::ST_WAIT: begin
                if (wait_sync_n) begin
                    next_r.state = emc_pkg::ST_IDLE;                               // [R14] [R15]
                end
            end
            emc_pkg::ST_HOLD: begin
                // far master owns the bus
                if (hold_req_sync_n) begin                                         // [R19]
                    next_r.state            = emc_pkg::ST_IDLE;
                    next_r.bus_hold_grant_n = 1'b1;                                // [R18]
                    next_r.addr_oe          = 1'b1;
                    next_r.ctrl_oe          = 1'b1;
                end
            end
        endcase

        // access end: strobes and select drop
        if ((r.state == emc_pkg::ST_ACCESS && next_r.state == emc_pkg::ST_IDLE) ||
            (r.state == emc_pkg::ST_WAIT && next_r.state == emc_pkg::ST_IDLE)) begin
            next_r.bank_chip_select_n = 8'hFF;
            next_r.read_strobe_n      = 1'b1;                                      // [R14]
            next_r.write_strobe_n     = 1'b1;
            next_r.data_oe            = 1'b0;
            next_r.req_done           = 1'b1;
            // read data taken at strobe end
            if (!r.is_write) begin
                next_r.req_rdata = swap32(mem_data_in, big_endian);                // [R06]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r.state                  <= emc_pkg::ST_IDLE;
            r.settle                 <= 2'h0;
            r.boot_done              <= 1'b0;
            r.boot_bank_width_status <= 2'h0;
            r.count                  <= 4'h0;
            r.is_write               <= 1'b0;
            r.wait_on                <= 1'b0;
            r.bank_chip_select_n     <= 8'hFF;
            r.read_strobe_n          <= 1'b1;
            r.write_strobe_n         <= 1'b1;
            r.mem_addr               <= 27'h0;
            r.sdram_bank_addr        <= 2'h0;
            r.mem_data_out           <= 32'h0;
            r.addr_oe                <= 1'b1;
            r.ctrl_oe                <= 1'b1;
            r.data_oe                <= 1'b0;
            r.bus_hold_grant_n       <= 1'b1;
            r.req_ready              <= 1'b0;
            r.req_done               <= 1'b0;
            r.req_error              <= 1'b0;
            r.req_rdata              <= 32'h0;
            r.sdram_cke              <= 1'b1;
            r.sdram_self_refresh     <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign req_ready              = r.req_ready;
    assign req_done               = r.req_done;
    assign req_error              = r.req_error;
    assign req_rdata              = r.req_rdata;
    assign bank_chip_select_n     = r.bank_chip_select_n;
    assign read_strobe_n          = r.read_strobe_n;
    assign write_strobe_n         = r.write_strobe_n;
    assign mem_addr               = r.mem_addr;
    assign sdram_bank_addr        = r.sdram_bank_addr;
    assign mem_data_out           = r.mem_data_out;
    assign addr_oe                = r.addr_oe;
    assign ctrl_oe                = r.ctrl_oe;
    assign data_oe                = r.data_oe;
    assign bus_hold_grant_n       = r.bus_hold_grant_n;
    assign boot_bank_width_status = r.boot_bank_width_status;
    assign sdram_cke              = r.sdram_cke;
    assign sdram_self_refresh     = r.sdram_self_refresh;

endmodule : external_memory_controller

//--- dv/emc_monitor.sv
/*
 * checker of the controller pins, bound into the top module.
 * assumes one bus clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module emc_monitor (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [1:0] boot_mode_pins,
    input wire logic [7:0] bank_wait_enable,
    input wire logic [1:0] bank67_is_sdram,
    input wire logic       self_refresh_req,
    input wire logic       power_down_req,
    input wire logic       ext_wait_n,
    input wire logic       bus_hold_request_n,
    input wire logic       req_ready,
    input wire logic       req_done,
    input wire logic       req_error,
    input wire logic [7:0] bank_chip_select_n,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic [1:0] sdram_bank_addr,
    input wire logic       addr_oe,
    input wire logic       ctrl_oe,
    input wire logic       data_oe,
    input wire logic       bus_hold_grant_n,
    input wire logic [1:0] boot_bank_width_status,
    input wire logic       sdram_cke,
    input wire logic       sdram_self_refresh
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    logic strobe;
    assign strobe = !(read_strobe_n && write_strobe_n);
    // pin runs two flops late
    sequence wait_held;
        (strobe && !ext_wait_n && bank_wait_enable[1] && !bank_chip_select_n[1])[*3];
    endsequence
    sequence req_gone;
        bus_hold_request_n[*4];
    endsequence
    a_wait_stretch: assert property (wait_held |=> strobe)
        else $error("wait not held");
    a_hold_release: assert property (req_gone |=> bus_hold_grant_n)
        else $error("grant kept");
    a_grant_cause: assert property ($fell(bus_hold_grant_n) |-> $past(!bus_hold_request_n, 2))
        else $error("stray grant");
    a_grant_floats: assert property (!bus_hold_grant_n |-> !(addr_oe || ctrl_oe || data_oe))
        else $error("bus driven in hold");
    a_grant_idle: assert property (!bus_hold_grant_n |-> &bank_chip_select_n && !strobe)
        else $error("access in hold");
    a_select_onehot: assert property (strobe |-> $onehot(~bank_chip_select_n))
        else $error("select not one-hot");
    a_error_quiet: assert property (req_error |-> req_done && !strobe)
        else $error("bad error pulse");
    a_boot_status: assert property (req_ready |-> boot_bank_width_status == boot_mode_pins)
        else $error("boot status wrong");
    a_sdram_zero: assert property (!(&bank_chip_select_n) && bank67_is_sdram == 2'h0
        |-> sdram_bank_addr == 2'h0)
        else $error("stray sdram bits");
    a_cke_cause: assert property (!sdram_cke |-> $past(self_refresh_req || power_down_req))
        else $error("stray cke low");
    a_refresh_cause: assert property (sdram_self_refresh |-> $past(self_refresh_req))
        else $error("stray self refresh");
endmodule : emc_monitor

bind external_memory_controller emc_monitor mon (
    .clk, .reset_n, .boot_mode_pins, .bank_wait_enable, .bank67_is_sdram,
    .self_refresh_req, .power_down_req, .ext_wait_n, .bus_hold_request_n, .req_ready,
    .req_done, .req_error, .bank_chip_select_n, .read_strobe_n, .write_strobe_n,
    .sdram_bank_addr, .addr_oe, .ctrl_oe, .data_oe, .bus_hold_grant_n,
    .boot_bank_width_status, .sdram_cke, .sdram_self_refresh
);

//--- dv/ext_memory_model.sv
/*
 * static memory model: pattern reads, write capture, wait pin.
 * assumes the controller strobes, one bus clock.
 */
`timescale 1ns/1ps
module ext_memory_model (
    input  wire logic        clk,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [26:0] mem_addr,
    input  wire logic [31:0] mem_data_out,
    input  wire logic        data_oe,
    input  wire logic [7:0]  wait_len,
    output logic             ext_wait_n,
    output logic [31:0]      mem_data_in,
    output logic [31:0]      wr_seen
);
    logic [7:0] cnt = 8'h00;
    logic       flip = 1'b0;
    initial {ext_wait_n, wr_seen} = {1'b1, 32'h0};
    always @(posedge clk) begin
        flip <= ~flip;
        cnt <= (read_strobe_n && write_strobe_n) ? 8'h00 : cnt + 8'h01;
        // pulled up when not stretching
        ext_wait_n <= !(!(read_strobe_n && write_strobe_n) && cnt < wait_len);
        if (!write_strobe_n && data_oe) begin
            wr_seen <= mem_data_out;
        end
    end
    // released lines toggle: no stale word
    assign mem_data_in = !read_strobe_n ? {5'h00, mem_addr} ^ 32'h5A5A_5A5A : {32{flip}};
endmodule : ext_memory_model

//--- dv/external_memory_controller_test.sv
/*
 * self-checking bench of the controller.
 * assumes the memory model and bound checker.
 */
`timescale 1ns/1ps
module external_memory_controller_test;
    logic        clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic [31:0] req_addr = '0, req_wdata = '0, bank_access_cycles = '0;
    logic [15:0] bank_width = '0;
    logic [7:0]  bank_wait_enable = '0, wait_len = '0, bank_chip_select_n, cs_seen;
    logic [2:0]  bank67_size = '0;
    logic [1:0]  bank67_is_sdram = '0, boot_mode_pins = '0, sdram_bank_addr, ba_seen;
    logic        sdram_four_banks = 1'b0, big_endian = 1'b0, self_refresh_req = 1'b0;
    logic        power_down_req = 1'b0, bus_hold_request_n = 1'b1, err_seen;
    logic        ext_wait_n, req_ready, req_done, req_error, read_strobe_n, write_strobe_n;
    logic        addr_oe, ctrl_oe, data_oe, bus_hold_grant_n, sdram_cke, sdram_self_refresh;
    logic [31:0] req_rdata, mem_data_in, mem_data_out, wr_seen, rd_seen;
    logic [26:0] mem_addr, ma_seen;
    logic [1:0]  boot_bank_width_status;
    int          len, miscompares = 0, compares = 0;
    external_memory_controller uut (.clk, .reset_n, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .req_done, .req_error, .req_rdata, .bank_width,
        .bank_wait_enable, .bank_access_cycles, .bank67_size, .bank67_is_sdram,
        .sdram_four_banks, .big_endian, .self_refresh_req, .power_down_req, .boot_mode_pins,
        .ext_wait_n, .bus_hold_request_n, .mem_data_in, .bank_chip_select_n, .read_strobe_n,
        .write_strobe_n, .mem_addr, .sdram_bank_addr, .mem_data_out, .addr_oe, .ctrl_oe,
        .data_oe, .bus_hold_grant_n, .boot_bank_width_status, .sdram_cke, .sdram_self_refresh);
    ext_memory_model mem (.clk, .read_strobe_n, .write_strobe_n, .mem_addr, .mem_data_out,
        .data_oe, .wait_len, .ext_wait_n, .mem_data_in, .wr_seen);
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] swap(input logic [31:0] w, input logic be);
        return be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction : swap
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic step(inout int n);
        @(posedge clk);
        n++;
    endtask : step
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic do_reset(input logic [1:0] pins);
        int n;
        n = 0;
        reset_n <= 1'b0;
        boot_mode_pins <= pins;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        do step(n); while (req_ready !== 1'b1 && n < 20);
    endtask : do_reset
    // request held until ready; strobe cycles counted
    task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        len = 0;
        cs_seen = 8'hFF;
        {req_valid, req_write, req_addr, req_wdata} <= {1'b1, w, a, d};
        do step(n); while (req_ready !== 1'b1 && n < 400);
        req_valid <= 1'b0;
        do begin
            step(n);
            if (!(read_strobe_n && write_strobe_n)) begin
                len++;
                {cs_seen, ma_seen, ba_seen} = {bank_chip_select_n, mem_addr, sdram_bank_addr};
            end
        end while (req_done !== 1'b1 && n < 400);
        {rd_seen, err_seen} = {req_rdata, req_error};
        if (n >= 400) chk("handshake", 32'h1, 32'h0);
    endtask : access
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        logic [31:0] a, d, ac, sb;
        logic [15:0] bw;
        logic [2:0]  bank;
        logic        w, be;
        int          sh, n;
        void'($urandom(8660));
        for (int b = 0; b < 4; b++) begin
            do_reset(2'(b));
            chk("boot status", 32'(b), boot_bank_width_status);
            access(1'b0, 32'h0000_0100, '0);
            chk("boot address", (b == 2) ? 32'h40 : 32'h80, ma_seen);
        end
        for (int i = 0; i < 60; i++) begin
            {bank, d, ac, bw, w, be} = {3'($urandom_range(5, 0)), $urandom, $urandom,
                16'($urandom), 2'($urandom)};
            a = {2'b00, bank, 27'($urandom)};
            {bank_width, bank_access_cycles, big_endian} <= {bw, ac, be};
            bank_wait_enable <= 8'($urandom);
            sh = (bank == 3'h0) ? 1 : (bw[2*bank +: 2] == 2'h0) ? 0 : (bw[2*bank +: 2] == 2'h1) ? 1 : 2;
            access(w, a, d);
            chk("bank select", 8'(~(8'h01 << bank)), cs_seen);
            chk("mem addr", a[26:0] >> sh, ma_seen);
            chk("strobe len", (ac[4*bank +: 4] == 4'h0) ? 32'h1 : ac[4*bank +: 4], len);
            if (w) chk("write data", swap(d, be), wr_seen);
            else chk("read data", swap({5'h00, a[26:0] >> sh} ^ 32'h5A5A_5A5A, be), rd_seen);
        end
        bank67_is_sdram <= 2'h3;
        for (int sz = 0; sz < 7; sz++) begin
            {bank67_size, sdram_four_banks} <= {3'(sz), 1'(sz)};
            sb = 32'h0020_0000 << sz;
            a = 32'h3000_0000 + sb + ($urandom & (sb - 1));
            access(1'b0, a, '0);
            chk("bank7 cs", 32'h7F, cs_seen);
            chk("sdram bits", sz[0] ? {a[20+sz], a[19+sz]} : {1'b0, a[20+sz]}, ba_seen);
            access(1'b0, 32'h3000_0000 + (a & (sb - 1)), '0);
            chk("bank6 cs", 32'hBF, cs_seen);
            access(1'b0, 32'h3000_0000 + (sb << 1), '0);
            chk("past bank7", 32'h1, err_seen & (len == 0));
        end
        {bank67_is_sdram, bank_width, bank_access_cycles} <= {2'h0, 16'hAAAA, 32'h6666_6666};
        // six-cycle strobe covers the sync delay
        for (int k = 0; k < 4; k++) begin
            n = (k < 2) ? 5 : 9;
            wait_len <= 8'(n);
            bank_wait_enable <= (k == 3) ? 8'h00 : 8'h02;
            access(1'(k), 32'h0800_0040, 32'h1234_5678);
            if (k == 3) chk("no stretch", 32'h6, len);
            else chk("stretched", 32'h1, len >= n + 3 && len <= n + 6);
        end
        wait_len <= 8'h00;
        n = 0;
        bus_hold_request_n <= 1'b0;
        do step(n); while (bus_hold_grant_n !== 1'b0 && n < 10);
        chk("grant delay", 32'h1, n < 6);
        step(n);
        chk("floated", 32'h0, {addr_oe, ctrl_oe, data_oe, req_ready});
        n = 0;
        bus_hold_request_n <= 1'b1;
        do step(n); while (bus_hold_grant_n !== 1'b1 && n < 10);
        chk("grant release", 32'h1, n < 6);
        step(n);
        chk("redriven", 32'h3, {addr_oe, ctrl_oe});
        for (int p = 0; p < 3; p++) begin
            {self_refresh_req, power_down_req} <= {p == 0, p == 1};
            repeat (4) @(posedge clk);
            chk("low power", (p == 2) ? 32'h5 : {p == 0, 1'b0}, {sdram_cke, sdram_self_refresh, req_ready});
        end
        results();
    end
endmodule : external_memory_controller_test
